// ---- dcf_pkg.sv ----
// shared constants of the dual-clock fifo flag block
package dcf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // apb register byte offsets
    localparam logic [7:0] REG_AE_OFF   = 8'h00;
    localparam logic [7:0] REG_AF_OFF   = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_COUNT    = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // status register bit positions
    localparam int ST_FULL_N   = 0;
    localparam int ST_EMPTY_N  = 1;
    localparam int ST_AEMPTY_N = 2;
    localparam int ST_AFULL_N  = 3;
    localparam int ST_HALF_N   = 4;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt event bit positions
    localparam int IRQ_W      = 4;
    localparam int IRQ_FULL   = 0;
    localparam int IRQ_EMPTY  = 1;
    localparam int IRQ_WR_REF = 2;
    localparam int IRQ_RD_REF = 3;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [15:0]      RST_AE_OFF   = 16'h007f;
    localparam logic [15:0]      RST_AF_OFF   = 16'h007f;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
    localparam logic             RST_FULL_N   = 1'b1;
    localparam logic             RST_EMPTY_N  = 1'b0;
    localparam logic             RST_AEMPTY_N = 1'b0;
    localparam logic             RST_AFULL_N  = 1'b1;
    localparam logic             RST_HALF_N   = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // timing: pointer skew between the write side and the read side
    localparam int CLK_NS   = 4;
    localparam int SKEW_NS  = 5;
    localparam int SKEW_CYC = (SKEW_NS + CLK_NS - 1) / CLK_NS;

endpackage : dcf_pkg

// ---- dcf_mem.sv ----
// storage array with registered read port
`timescale 1ns/1ns
module dcf_mem #(
    parameter int W     = 18,
    parameter int DEPTH = 8192,
    parameter int AW    = 13
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // read port
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);

    typedef struct packed {
        logic [W-1:0] dout;
    } dcf_mem_state_t;

    logic [W-1:0]   array [DEPTH];
    dcf_mem_state_t st;
    dcf_mem_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // array write, no reset on the cells
    always_ff @(posedge clk) begin
        if (wr_en) begin
            array[wr_addr] <= wr_data;
        end
    end

    // output word changes only on a read, zero after reset
    always_comb begin
        next_st = st;
        if (rd_en) begin
            next_st.dout = array[rd_addr];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.dout;

endmodule : dcf_mem

// ---- dcf_delay.sv ----
// fixed pipeline delay for pointers passed between fifo sides
`timescale 1ns/1ns
module dcf_delay #(
    parameter int W      = 14,
    parameter int STAGES = 2
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [STAGES-1:0][W-1:0] stage;
    } dcf_dly_state_t;

    dcf_dly_state_t st;
    dcf_dly_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // shift by one stage each cycle
    always_comb begin
        next_st = st;
        next_st.stage[0] = d;
        for (int i = 1; i < STAGES; i++) begin
            next_st.stage[i] = st.stage[i-1];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.stage[STAGES-1];

endmodule : dcf_delay

// ---- dcf_fifo.sv ----
// fifo core with status flags, apb registers and interrupt
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ns
module dcf_fifo #(
    parameter int W     = 18,
    parameter int DEPTH = 8192,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    // write side
    input  wire logic         wr_tick,
    input  wire logic         wr_en_n,
    input  wire logic [W-1:0] wr_data,
    // read side
    input  wire logic         rd_tick,
    input  wire logic         rd_en_n,
    input  wire logic         oe_n,
    output logic      [W-1:0] rd_data,
    output logic              rd_data_oe,
    // flags and mode
    input  wire logic         flag_timing_select,
    output logic              full_flag_n,
    output logic              empty_flag_n,
    output logic              almost_empty_flag_n,
    output logic              almost_full_flag_n,
    output logic              half_full_flag_n,
    // interrupt
    output logic              irq
);

    localparam int              SKEW    = dcf_pkg::SKEW_CYC;
    localparam logic [AW:0]     DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0]     HALF_C  = (AW+1)'(DEPTH / 2);

    typedef struct packed {
        logic [AW:0]                 wptr;
        logic [AW:0]                 rptr;
        logic                        full_n;
        logic                        empty_n;
        logic                        ae_n;
        logic                        af_n;
        logic                        hf_n;
        logic [15:0]                 ae_off;
        logic [15:0]                 af_off;
        logic [dcf_pkg::IRQ_W-1:0]   irq_stat;
        logic [dcf_pkg::IRQ_W-1:0]   irq_mask;
        logic [31:0]                 prdata;
        logic                        pslverr;
    } dcf_state_t;

    dcf_state_t                st;
    dcf_state_t                next_st;
    logic [AW:0]               wptr_seen;
    logic [AW:0]               rptr_seen;
    logic                      do_wr;
    logic                      do_rd;
    logic [AW:0]               nw;
    logic [AW:0]               nr;
    logic [AW:0]               cnt_w_next;
    logic [AW:0]               cnt_r_next;
    logic [dcf_pkg::IRQ_W-1:0] ev;
    logic                      apb_wr;
    logic [31:0]               status_word;
    logic [31:0]               rd_word;
    logic                      rd_hit;

    ////////////////////////////////////////////////////////////////////////////
    // pointer crossing between sides, delayed by the skew time
    dcf_delay #(.W(AW+1), .STAGES(SKEW)) u_wptr_dly (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (st.wptr),
        .q     (wptr_seen)
    );

    dcf_delay #(.W(AW+1), .STAGES(SKEW)) u_rptr_dly (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (st.rptr),
        .q     (rptr_seen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // storage
    dcf_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr_en   (do_wr),
        .wr_addr (st.wptr[AW-1:0]),
        .wr_data (wr_data),
        .rd_en   (do_rd),
        .rd_addr (st.rptr[AW-1:0]),
        .rd_data (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // accepted transfers and next occupancy seen by each side
    assign do_wr = wr_tick && !wr_en_n && st.full_n;
    assign do_rd = rd_tick && !rd_en_n && st.empty_n;
    assign nw = st.wptr + (AW+1)'(do_wr);
    assign nr = st.rptr + (AW+1)'(do_rd);
    assign cnt_w_next = nw - rptr_seen;
    assign cnt_r_next = wptr_seen - nr;

    // events feeding the sticky interrupt bits
    always_comb begin
        ev = '0;
        ev[dcf_pkg::IRQ_FULL]   = st.full_n && wr_tick && (cnt_w_next == DEPTH_C);
        ev[dcf_pkg::IRQ_EMPTY]  = st.empty_n && rd_tick && (wptr_seen == nr);
        ev[dcf_pkg::IRQ_WR_REF] = wr_tick && !wr_en_n && !st.full_n;
        ev[dcf_pkg::IRQ_RD_REF] = rd_tick && !rd_en_n && !st.empty_n;
    end

    // register read mux
    always_comb begin
        status_word = '0;
        status_word[dcf_pkg::ST_FULL_N]   = st.full_n;
        status_word[dcf_pkg::ST_EMPTY_N]  = st.empty_n;
        status_word[dcf_pkg::ST_AEMPTY_N] = st.ae_n;
        status_word[dcf_pkg::ST_AFULL_N]  = st.af_n;
        status_word[dcf_pkg::ST_HALF_N]   = st.hf_n;
        rd_hit  = 1'b1;
        rd_word = '0;
        case (paddr)
            dcf_pkg::REG_AE_OFF:   rd_word = {16'h0000, st.ae_off};
            dcf_pkg::REG_AF_OFF:   rd_word = {16'h0000, st.af_off};
            dcf_pkg::REG_STATUS:   rd_word = status_word;
            dcf_pkg::REG_COUNT:    rd_word = 32'((AW+1)'(st.wptr - rptr_seen));
            dcf_pkg::REG_IRQ_STAT: rd_word = 32'(st.irq_stat);
            dcf_pkg::REG_IRQ_MASK: rd_word = 32'(st.irq_mask);
            default:               rd_hit  = 1'b0;
        endcase
    end

    assign apb_wr = psel && penable && pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_st = st;
        next_st.wptr = nw;
        next_st.rptr = nr;
        // full updates on write ticks only, sees delayed read pointer
        if (wr_tick) begin
            next_st.full_n = (cnt_w_next != DEPTH_C);
        end
        // empty updates on read ticks only, sees delayed write pointer
        if (rd_tick) begin
            next_st.empty_n = (wptr_seen != nr);
        end
        // almost-empty: low while held words at or below offset
        if (flag_timing_select || rd_tick) begin
            next_st.ae_n = 32'(cnt_r_next) > 32'(st.ae_off);
        end
        // almost-full: low once free space at or below offset
        if (flag_timing_select || wr_tick) begin
            next_st.af_n = 32'(cnt_w_next) < (32'(DEPTH) - 32'(st.af_off));
        end
        next_st.hf_n = (cnt_w_next <= HALF_C);
        // apb setup cycle captures read data and error
        if (psel && !penable) begin
            next_st.prdata  = pwrite ? 32'h0000_0000 : rd_word;
            next_st.pslverr = !rd_hit;
        end
        // apb writes at the access edge
        if (apb_wr && rd_hit) begin
            case (paddr)
                dcf_pkg::REG_AE_OFF:   next_st.ae_off = pwdata[15:0];
                dcf_pkg::REG_AF_OFF:   next_st.af_off = pwdata[15:0];
                dcf_pkg::REG_IRQ_MASK: next_st.irq_mask = pwdata[dcf_pkg::IRQ_W-1:0];
                dcf_pkg::REG_IRQ_STAT: next_st.irq_stat = st.irq_stat
                                                        & ~pwdata[dcf_pkg::IRQ_W-1:0];
                default:               next_st.irq_mask = st.irq_mask;
            endcase
        end
        // new events win over a clear in the same cycle
        next_st.irq_stat = next_st.irq_stat | ev;
    end

    // state register, synchronous reset, ticks may run throughout
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st          <= '0;
            st.full_n   <= dcf_pkg::RST_FULL_N;
            st.empty_n  <= dcf_pkg::RST_EMPTY_N;
            st.ae_n     <= dcf_pkg::RST_AEMPTY_N;
            st.af_n     <= dcf_pkg::RST_AFULL_N;
            st.hf_n     <= dcf_pkg::RST_HALF_N;
            st.ae_off   <= dcf_pkg::RST_AE_OFF;
            st.af_off   <= dcf_pkg::RST_AF_OFF;
            st.irq_mask <= dcf_pkg::RST_IRQ_MASK;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign full_flag_n         = st.full_n;
    assign empty_flag_n        = st.empty_n;
    assign almost_empty_flag_n = st.ae_n;
    assign almost_full_flag_n  = st.af_n;
    assign half_full_flag_n    = st.hf_n;
    assign rd_data_oe          = !oe_n;
    assign pready              = 1'b1;
    assign prdata              = st.prdata;
    assign pslverr             = st.pslverr && psel && penable;
    assign irq                 = |(st.irq_stat & st.irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_full_blocks;
        @(posedge clk) disable iff (!rst_n)
        wr_tick && !wr_en_n && !full_flag_n |=> st.wptr == $past(st.wptr);
    endproperty
    a_full_blocks: assert property (p_full_blocks)
        else $error("write taken while full");

    property p_empty_blocks;
        @(posedge clk) disable iff (!rst_n)
        rd_tick && !empty_flag_n |=> st.rptr == $past(st.rptr) && $stable(rd_data);
    endproperty
    a_empty_blocks: assert property (p_empty_blocks)
        else $error("read taken while empty");

    property p_write_capture;
        @(posedge clk) disable iff (!rst_n)
        wr_tick && !wr_en_n && full_flag_n |=> st.wptr == $past(st.wptr) + 1'b1;
    endproperty
    a_write_capture: assert property (p_write_capture)
        else $error("write not captured");

    property p_full_release;
        @(posedge clk) disable iff (!rst_n)
        $rose(full_flag_n) |-> $past(wr_tick) && $past(st.wptr - rptr_seen) != DEPTH_C;
    endproperty
    a_full_release: assert property (p_full_release)
        else $error("full released off a write tick");

    property p_empty_release;
        @(posedge clk) disable iff (!rst_n)
        $rose(empty_flag_n) |-> $past(rd_tick) && $past(wptr_seen) != $past(st.rptr);
    endproperty
    a_empty_release: assert property (p_empty_release)
        else $error("empty released without data");

    property p_reset_state;
        @(posedge clk)
        $rose(rst_n) |-> !empty_flag_n && full_flag_n && rd_data == '0 && st.wptr == '0;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("bad state after reset");

    property p_first_word;
        @(posedge clk) disable iff (!rst_n)
        $rose(empty_flag_n) ##0 rd_tick && !rd_en_n |=> st.rptr == $past(st.rptr) + 1'b1;
    endproperty
    a_first_word: assert property (p_first_word)
        else $error("first word not readable");

    property p_ae_sync;
        @(posedge clk) disable iff (!rst_n)
        rd_tick && !flag_timing_select
            |=> almost_empty_flag_n == (32'($past(cnt_r_next)) > 32'($past(st.ae_off)));
    endproperty
    a_ae_sync: assert property (p_ae_sync)
        else $error("almost-empty mismatch");

    property p_ae_hold;
        @(posedge clk) disable iff (!rst_n)
        !rd_tick && !flag_timing_select |=> $stable(almost_empty_flag_n);
    endproperty
    a_ae_hold: assert property (p_ae_hold)
        else $error("almost-empty moved off a read tick");

    property p_af_async;
        @(posedge clk) disable iff (!rst_n)
        flag_timing_select
            |=> almost_full_flag_n ==
                (32'($past(cnt_w_next)) < 32'(DEPTH) - 32'($past(st.af_off)));
    endproperty
    a_af_async: assert property (p_af_async)
        else $error("almost-full free mode mismatch");

    property p_hold_output;
        @(posedge clk) disable iff (!rst_n)
        !(rd_tick && !rd_en_n) |=> $stable(rd_data);
    endproperty
    a_hold_output: assert property (p_hold_output)
        else $error("output word changed without read");

    property p_irq_sticky;
        @(posedge clk) disable iff (!rst_n)
        rd_tick && !rd_en_n && !empty_flag_n |=> st.irq_stat[dcf_pkg::IRQ_RD_REF];
    endproperty
    a_irq_sticky: assert property (p_irq_sticky)
        else $error("refused read not flagged");

    c_fill: cover property (@(posedge clk) disable iff (!rst_n) $fell(full_flag_n));
    c_drain: cover property (@(posedge clk) disable iff (!rst_n) $fell(empty_flag_n));
    c_first: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(empty_flag_n) ##0 rd_tick && !rd_en_n);
    c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));

endmodule : dcf_fifo

// ---- dcf_agent.sv ----
// writing and reading agents on their own ticks, facing the fifo
`timescale 1ns/1ns
module dcf_agent #(
    parameter int WDIV = 3,
    parameter int RDIV = 5,
    parameter int W    = 18
) (
    // clock
    input  wire logic         clk,
    // write side
    output logic              wr_tick,
    output logic              wr_en_n,
    output logic      [W-1:0] wr_data,
    // read side
    output logic              rd_tick,
    output logic              rd_en_n,
    input  wire logic [W-1:0] rd_data
);
    int wcnt = 0;
    int rcnt = 2;

    ////////////////////////////////////////////////////////////////////////////
    // free-running ticks, unrelated in phase, also through reset
    always @(posedge clk) begin
        wcnt <= (wcnt == WDIV - 1) ? 0 : wcnt + 1;
        rcnt <= (rcnt == RDIV - 1) ? 0 : rcnt + 1;
    end
    assign wr_tick = (wcnt == 0);
    assign rd_tick = (rcnt == 0);

    initial begin
        wr_en_n = 1'b1;
        rd_en_n = 1'b1;
        wr_data = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one word on one write tick; released data shows the inverse
    task automatic push(input logic [W-1:0] d);
        do @(posedge clk); while (wcnt != WDIV - 1);
        wr_en_n <= 1'b0;
        wr_data <= d;
        @(posedge clk);
        wr_en_n <= 1'b1;
        wr_data <= ~d;
    endtask : push

    // one read on one read tick; word taken the cycle after
    task automatic pull(output logic [W-1:0] q);
        do @(posedge clk); while (rcnt != RDIV - 1);
        rd_en_n <= 1'b0;
        @(posedge clk);
        rd_en_n <= 1'b1;
        @(posedge clk);
        q = rd_data;
    endtask : pull
endmodule : dcf_agent

// ---- dcf_fifo_test.sv ----
// self-checking testbench of the dual-clock fifo flag block
`timescale 1ns/1ns
module dcf_fifo_test;
    localparam int DEPTH  = 16;
    localparam int WDIV   = 3;
    localparam int RDIV   = 5;
    localparam int SETTLE = 2 * RDIV + dcf_pkg::SKEW_CYC + 4;

    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        wr_tick, wr_en_n, rd_tick, rd_en_n, oe_n, rd_data_oe, sel, irq;
    logic [17:0] wr_data, rd_data;
    logic        full_n, empty_n, aempty_n, afull_n, half_n;
    logic [4:0]  flags;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc       = 0;

    assign flags = {half_n, afull_n, aempty_n, empty_n, full_n};

    dcf_fifo #(.DEPTH(DEPTH)) DUT (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wr_tick(wr_tick), .wr_en_n(wr_en_n), .wr_data(wr_data),
        .rd_tick(rd_tick), .rd_en_n(rd_en_n), .oe_n(oe_n), .rd_data(rd_data),
        .rd_data_oe(rd_data_oe), .flag_timing_select(sel), .full_flag_n(full_n),
        .empty_flag_n(empty_n), .almost_empty_flag_n(aempty_n),
        .almost_full_flag_n(afull_n), .half_full_flag_n(half_n), .irq(irq)
    );

    dcf_agent #(.WDIV(WDIV), .RDIV(RDIV)) agt (
        .clk(clk), .wr_tick(wr_tick), .wr_en_n(wr_en_n), .wr_data(wr_data),
        .rd_tick(rd_tick), .rd_en_n(rd_en_n), .rd_data(rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare, apb access and verdict
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, exp, q);
    endtask : rreg

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        // let the written value reach the outputs before anyone looks
        @(posedge clk);
    endtask : wreg

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [17:0] q;
        logic [31:0] r;
        logic        e;
        int          n;
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; oe_n = 1'b0; sel = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset state with ticks running
        chk("flags", 32'h19, {27'h0, flags});
        chk("rd_data", 32'h0, {14'h0, rd_data});
        chk("oe on", 32'h1, {31'h0, rd_data_oe});
        oe_n <= 1'b1;
        @(posedge clk);
        chk("oe off", 32'h0, {31'h0, rd_data_oe});
        oe_n <= 1'b0;
        rreg("ae_off", dcf_pkg::REG_AE_OFF, 32'h7f);
        rreg("af_off", dcf_pkg::REG_AF_OFF, 32'h7f);
        rreg("status", dcf_pkg::REG_STATUS, 32'h19);
        rreg("mask", dcf_pkg::REG_IRQ_MASK, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        $display("test reset done");
        // refused read while empty, interrupt raise, mask, clear
        agt.pull(q);
        chk("kept word", 32'h0, {14'h0, q});
        apb(1'b0, dcf_pkg::REG_IRQ_STAT, 32'h0, r, e);
        chk("read refused", 32'h1, {31'h0, r[3]});
        chk("irq masked", 32'h0, {31'h0, irq});
        wreg(dcf_pkg::REG_IRQ_MASK, 32'hf);
        chk("irq raised", 32'h1, {31'h0, irq});
        wreg(dcf_pkg::REG_IRQ_STAT, 32'hf);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test refused read done");
        // first word into empty buffer
        agt.push(18'h2a5a5);
        n = 0;
        while (empty_n !== 1'b1 && n < 2 * RDIV + dcf_pkg::SKEW_CYC) begin
            @(posedge clk);
            n++;
        end
        chk("empty release", 32'h1, {31'h0, empty_n});
        agt.pull(q);
        chk("first word", 32'h2a5a5, {14'h0, q});
        agt.pull(q);
        chk("held word", 32'h2a5a5, {14'h0, q});
        $display("test first word done");
        // almost-empty boundary in both timing modes
        for (int m = 0; m < 2; m++) begin
            sel <= m[0];
            wreg(dcf_pkg::REG_AE_OFF, 32'h4);
            for (int i = 0; i < 4; i++) agt.push(18'(32'h100 + i));
            repeat (SETTLE) @(posedge clk);
            chk("ae at n", 32'h0, {31'h0, aempty_n});
            agt.push(18'h104);
            repeat (SETTLE) @(posedge clk);
            chk("ae above n", 32'h1, {31'h0, aempty_n});
            rreg("count", dcf_pkg::REG_COUNT, 32'h5);
            for (int i = 0; i < 5; i++) begin
                agt.pull(q);
                chk("order", 32'h100 + i, {14'h0, q});
            end
        end
        $display("test almost empty done");
        // fill to full, refused write, release, drain
        wreg(dcf_pkg::REG_AF_OFF, 32'h2);
        for (int i = 0; i < DEPTH; i++) agt.push(18'(32'h200 + i));
        repeat (SETTLE) @(posedge clk);
        chk("flags full", 32'h06, {27'h0, flags});
        rreg("status full", dcf_pkg::REG_STATUS, 32'h06);
        rreg("count full", dcf_pkg::REG_COUNT, DEPTH);
        agt.push(18'h3ffff);
        apb(1'b0, dcf_pkg::REG_IRQ_STAT, 32'h0, r, e);
        chk("full and refused", 32'h5, r & 32'h5);
        agt.pull(q);
        chk("head", 32'h200, {14'h0, q});
        n = 0;
        while (full_n !== 1'b1 && n < 2 * WDIV + dcf_pkg::SKEW_CYC + 1) begin
            @(posedge clk);
            n++;
        end
        chk("full release", 32'h1, {31'h0, full_n});
        for (int i = 1; i < DEPTH; i++) begin
            agt.pull(q);
            chk("drain", 32'h200 + i, {14'h0, q});
        end
        repeat (SETTLE) @(posedge clk);
        chk("empty after drain", 32'h0, {31'h0, empty_n});
        agt.pull(q);
        chk("last kept", 32'h200 + DEPTH - 1, {14'h0, q});
        wreg(dcf_pkg::REG_IRQ_STAT, 32'hf);
        $display("test full done");
        end_of_test();
    end
endmodule : dcf_fifo_test
